// ==== hdl/pet_pkg.sv ====
// Package: register map, reset values and mode codes of the edge timing block
package pet_pkg;

   // -----------------------------
   // Register bus
   // -----------------------------
   localparam int unsigned ADDR_W = 3;
   localparam int unsigned DATA_W = 8;

   localparam logic [2:0] RISE_DEADBAND_OFF = 3'h0;
   localparam logic [2:0] FALL_DEADBAND_OFF = 3'h1;
   localparam logic [2:0] FRAC_ADJUST_OFF   = 3'h2;
   localparam logic [2:0] RISE_BLANKING_OFF = 3'h3;
   localparam logic [2:0] FALL_BLANKING_OFF = 3'h4;
   localparam logic [2:0] STEERING_OFF      = 3'h5;

   // -----------------------------
   // Reset values and field layout
   // -----------------------------
   localparam logic [7:0] COUNT_RESET    = 8'h00;
   localparam logic [3:0] FRAC_RESET     = 4'h0;
   localparam logic [5:0] STEER_RESET    = 6'h01;
   localparam int unsigned FRAC_W        = 4;
   localparam int unsigned STEER_W       = 6;
   localparam logic [7:0] READ_ZERO      = 8'h00;

   // -----------------------------
   // Output modes and pins
   // -----------------------------
   typedef enum logic [3:0] {
      PET_MODE_SINGLE = 4'h0,
      PET_MODE_COMPL  = 4'h1,
      PET_MODE_THREE  = 4'hc
   } pet_mode_type;

   localparam int unsigned OUT_A = 0;
   localparam int unsigned OUT_B = 1;
   localparam int unsigned OUT_C = 2;
   localparam int unsigned OUT_D = 3;
   localparam int unsigned OUT_E = 4;
   localparam int unsigned OUT_F = 5;

   // -----------------------------
   // Interval timers
   // -----------------------------
   localparam int unsigned TMR_RISE_DB  = 0;
   localparam int unsigned TMR_FALL_DB  = 1;
   localparam int unsigned TMR_RISE_BLK = 2;
   localparam int unsigned TMR_FALL_BLK = 3;
   localparam int unsigned TMR_NUM      = 4;
   localparam logic [7:0] TMR_IDLE      = 8'h00;

endpackage

// ==== hdl/pet_timer_if.sv ====
// Interface between the edge logic and one interval timer
`timescale 1ns/1ps
interface pet_timer_if;
   logic       start;
   logic [7:0] load;
   logic       busy;

   modport ctl (output start, output load, input busy);
   modport tmr (input start, input load, output busy);
endinterface

// ==== hdl/pet_interval_timer.sv ====
// Down counter that flags an interval of programmed length
`timescale 1ns/1ps
module pet_interval_timer (
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic reset_n,
   // Control
   pet_timer_if.tmr  tif
);

   logic [7:0] cnt_r;

   // ---------------------------------
   // Count down from the loaded value
   // ---------------------------------
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         cnt_r <= pet_pkg::TMR_IDLE;
      end else if (tif.start) begin
         cnt_r <= tif.load;
      end else if (cnt_r != pet_pkg::TMR_IDLE) begin
         cnt_r <= cnt_r - 8'h01;
      end
   end

   assign tif.busy = (cnt_r != pet_pkg::TMR_IDLE);

endmodule

// ==== hdl/pet_edge_timing.sv ====
// Dead-band, blanking, fractional period adjust and output steering of one PWM channel
`timescale 1ns/1ps

module pet_edge_timing (
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       reset_n,
   // Register port
   input  wire logic [2:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic [7:0]      reg_rdata,
   // PWM core
   input  wire logic       pwm_raw,
   input  wire logic       period_event_in,
   input  wire logic [3:0] output_mode_select,
   output logic            period_event_out,
   output logic            period_extend,
   // Feedback and shutdown pins
   input  wire logic       feedback_pin,
   input  wire logic       shutdown_pin,
   output logic            feedback_accepted,
   output logic            shutdown_accepted,
   output logic            blanking_active,
   // Output pins
   output logic [5:0]      pwm_out
);

   // -----------------------------
   // Declarations
   // -----------------------------
   logic [7:0] rise_deadband_count_r;
   logic [7:0] fall_deadband_count_r;
   logic [3:0] fractional_adjust_r;
   logic [7:0] rise_blanking_count_r;
   logic [7:0] fall_blanking_count_r;
   logic [5:0] steer_enable_r;
   logic [7:0] reg_rdata_r;

   logic       pwm_d_r;
   logic       pwm_rise;
   logic       pwm_fall;
   logic       primary_nxt;
   logic       compl_nxt;
   logic       primary_r;
   logic       compl_r;
   logic       primary_d_r;
   logic [5:0] pwm_out_r;
   logic [5:0] pwm_out_nxt;

   logic [3:0] frac_acc_r;
   logic [4:0] frac_sum;
   logic       pend_event_r;
   logic       period_event_out_r;
   logic       period_extend_r;

   logic       fb_meta_r;
   logic       fb_sync_r;
   logic       sd_meta_r;
   logic       sd_sync_r;
   logic       blanking;
   logic       feedback_accepted_r;
   logic       shutdown_accepted_r;

   pet_timer_if tif [pet_pkg::TMR_NUM] ();

   // -----------------------------
   // Helpers
   // -----------------------------
   // An interval of n cycles starts in the edge cycle, so the timer covers n-1 more
   function automatic logic [7:0] tail_of(input logic [7:0] n);
      tail_of = (n == pet_pkg::TMR_IDLE) ? pet_pkg::TMR_IDLE : n - 8'h01;
   endfunction

   function automatic logic held_by(input logic edge_now,
                                    input logic [7:0] n,
                                    input logic busy);
      held_by = (edge_now && (n != pet_pkg::TMR_IDLE)) || busy;
   endfunction

   // Write strobe aimed at one register offset
   function automatic logic wr_hit(input logic       wr,
                                   input logic [2:0] addr,
                                   input logic [2:0] off);
      wr_hit = wr && (addr == off);
   endfunction

   // Three-phase pattern for each steering bit
   function automatic logic [5:0] three_phase_of(input logic [5:0] steer);
      logic [5:0] pat;
      pat = 6'h00;
      if (steer[pet_pkg::OUT_A]) pat = pat | 6'h09;
      if (steer[pet_pkg::OUT_B]) pat = pat | 6'h21;
      if (steer[pet_pkg::OUT_C]) pat = pat | 6'h11;
      if (steer[pet_pkg::OUT_D]) pat = pat | 6'h06;
      if (steer[pet_pkg::OUT_E]) pat = pat | 6'h12;
      if (steer[pet_pkg::OUT_F]) pat = pat | 6'h18;
      three_phase_of = pat;
   endfunction

   // -----------------------------
   // Register writes
   // -----------------------------
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         rise_deadband_count_r <= pet_pkg::COUNT_RESET;
      end else if (wr_hit(reg_wr, reg_addr, pet_pkg::RISE_DEADBAND_OFF)) begin
         rise_deadband_count_r <= reg_wdata;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         fall_deadband_count_r <= pet_pkg::COUNT_RESET;
      end else if (wr_hit(reg_wr, reg_addr, pet_pkg::FALL_DEADBAND_OFF)) begin
         fall_deadband_count_r <= reg_wdata;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         fractional_adjust_r <= pet_pkg::FRAC_RESET;
      end else if (wr_hit(reg_wr, reg_addr, pet_pkg::FRAC_ADJUST_OFF)) begin
         fractional_adjust_r <= reg_wdata[pet_pkg::FRAC_W-1:0];
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         rise_blanking_count_r <= pet_pkg::COUNT_RESET;
      end else if (wr_hit(reg_wr, reg_addr, pet_pkg::RISE_BLANKING_OFF)) begin
         rise_blanking_count_r <= reg_wdata;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         fall_blanking_count_r <= pet_pkg::COUNT_RESET;
      end else if (wr_hit(reg_wr, reg_addr, pet_pkg::FALL_BLANKING_OFF)) begin
         fall_blanking_count_r <= reg_wdata;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         steer_enable_r <= pet_pkg::STEER_RESET;
      end else if (wr_hit(reg_wr, reg_addr, pet_pkg::STEERING_OFF)) begin
         steer_enable_r <= reg_wdata[pet_pkg::STEER_W-1:0];
      end
   end

   // -----------------------------
   // Register reads
   // -----------------------------
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         reg_rdata_r <= pet_pkg::READ_ZERO;
      end else if (reg_rd) begin
         case (reg_addr)
            pet_pkg::RISE_DEADBAND_OFF: reg_rdata_r <= rise_deadband_count_r;
            pet_pkg::FALL_DEADBAND_OFF: reg_rdata_r <= fall_deadband_count_r;
            pet_pkg::FRAC_ADJUST_OFF:   reg_rdata_r <= {4'h0, fractional_adjust_r};
            pet_pkg::RISE_BLANKING_OFF: reg_rdata_r <= rise_blanking_count_r;
            pet_pkg::FALL_BLANKING_OFF: reg_rdata_r <= fall_blanking_count_r;
            pet_pkg::STEERING_OFF:      reg_rdata_r <= {2'h0, steer_enable_r};
            default:                    reg_rdata_r <= pet_pkg::READ_ZERO;
         endcase
      end else begin
         reg_rdata_r <= pet_pkg::READ_ZERO;
      end
   end

   assign reg_rdata = reg_rdata_r;

   // -----------------------------
   // Interval timers
   // -----------------------------
   for (genvar i = 0; i < pet_pkg::TMR_NUM; i++) begin : g_tmr
      pet_interval_timer u_tmr (
         .core_clk (core_clk),
         .reset_n  (reset_n),
         .tif      (tif[i])
      );
   end

   // -----------------------------
   // Dead band
   // -----------------------------
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         pwm_d_r <= 1'b0;
      end else begin
         pwm_d_r <= pwm_raw;
      end
   end

   assign pwm_rise = pwm_raw && !pwm_d_r;
   assign pwm_fall = !pwm_raw && pwm_d_r;

   assign tif[pet_pkg::TMR_RISE_DB].start = pwm_rise;
   assign tif[pet_pkg::TMR_RISE_DB].load  = tail_of(rise_deadband_count_r);
   assign tif[pet_pkg::TMR_FALL_DB].start = pwm_fall;
   assign tif[pet_pkg::TMR_FALL_DB].load  = tail_of(fall_deadband_count_r);

   // Newly active side waits out its count; the other side drops at once
   always_comb begin
      primary_nxt = pwm_raw &&
                    !held_by(pwm_rise, rise_deadband_count_r, tif[pet_pkg::TMR_RISE_DB].busy);
      compl_nxt   = !pwm_raw &&
                    !held_by(pwm_fall, fall_deadband_count_r, tif[pet_pkg::TMR_FALL_DB].busy);
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         primary_r <= 1'b0;
         compl_r   <= 1'b0;
      end else begin
         primary_r <= primary_nxt;
         compl_r   <= compl_nxt;
      end
   end

   // Delayed primary level marks the edges that start blanking
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         primary_d_r <= 1'b0;
      end else begin
         primary_d_r <= primary_r;
      end
   end

   // -----------------------------
   // Blanking
   // -----------------------------
   assign tif[pet_pkg::TMR_RISE_BLK].start = primary_r && !primary_d_r;
   assign tif[pet_pkg::TMR_RISE_BLK].load  = tail_of(rise_blanking_count_r);
   assign tif[pet_pkg::TMR_FALL_BLK].start = !primary_r && primary_d_r;
   assign tif[pet_pkg::TMR_FALL_BLK].load  = tail_of(fall_blanking_count_r);

   assign blanking =
      held_by(tif[pet_pkg::TMR_RISE_BLK].start, rise_blanking_count_r, tif[pet_pkg::TMR_RISE_BLK].busy) ||
      held_by(tif[pet_pkg::TMR_FALL_BLK].start, fall_blanking_count_r, tif[pet_pkg::TMR_FALL_BLK].busy);

   // Two-stage synchronisers for the asynchronous pins
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         fb_meta_r <= 1'b0;
         fb_sync_r <= 1'b0;
      end else begin
         fb_meta_r <= feedback_pin;
         fb_sync_r <= fb_meta_r;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         sd_meta_r <= 1'b0;
         sd_sync_r <= 1'b0;
      end else begin
         sd_meta_r <= shutdown_pin;
         sd_sync_r <= sd_meta_r;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         feedback_accepted_r <= 1'b0;
         shutdown_accepted_r <= 1'b0;
      end else begin
         feedback_accepted_r <= fb_sync_r && !blanking;
         shutdown_accepted_r <= sd_sync_r && !blanking;
      end
   end

   assign feedback_accepted = feedback_accepted_r;
   assign shutdown_accepted = shutdown_accepted_r;
   assign blanking_active   = blanking;

   // -----------------------------
   // Fractional period adjust
   // -----------------------------
   // Sixteenths accumulate; each carry stretches one period by a whole cycle
   assign frac_sum = {1'b0, frac_acc_r} + {1'b0, fractional_adjust_r};

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         frac_acc_r <= pet_pkg::FRAC_RESET;
      end else if (period_event_in) begin
         frac_acc_r <= frac_sum[3:0];
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         pend_event_r       <= 1'b0;
         period_event_out_r <= 1'b0;
         period_extend_r    <= 1'b0;
      end else begin
         pend_event_r       <= period_event_in && frac_sum[4];
         period_event_out_r <= (period_event_in && !frac_sum[4]) || pend_event_r;
         period_extend_r    <= period_event_in && frac_sum[4];
      end
   end

   assign period_event_out = period_event_out_r;
   assign period_extend    = period_extend_r;

   // -----------------------------
   // Output steering
   // -----------------------------
   always_comb begin
      pwm_out_nxt = 6'h00;
      case (pet_pkg::pet_mode_type'(output_mode_select))
         pet_pkg::PET_MODE_SINGLE: begin
            pwm_out_nxt = steer_enable_r & {6{primary_r}};
         end
         pet_pkg::PET_MODE_COMPL: begin
            pwm_out_nxt = steer_enable_r & {compl_r, primary_r, compl_r, primary_r, compl_r, primary_r};
         end
         pet_pkg::PET_MODE_THREE: begin
            pwm_out_nxt = three_phase_of(steer_enable_r) & {6{primary_r}};
         end
         default: begin
            pwm_out_nxt = 6'h00;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         pwm_out_r <= 6'h00;
      end else begin
         pwm_out_r <= pwm_out_nxt;
      end
   end

   assign pwm_out = pwm_out_r;

endmodule

// ==== testbench/pet_edge_timing_sva.sv ====
// Concurrent checks on the ports of the edge timing block
`timescale 1ns/1ps
module pet_edge_timing_sva (
   // Clock and reset
   input wire logic       core_clk,
   input wire logic       reset_n,
   // Register port
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   // PWM path
   input wire logic       pwm_raw,
   input wire logic       period_event_in,
   input wire logic [3:0] output_mode_select,
   input wire logic       period_event_out,
   input wire logic       period_extend,
   input wire logic       feedback_accepted,
   input wire logic       shutdown_accepted,
   input wire logic       blanking_active,
   input wire logic [5:0] pwm_out
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   // ------------------------
   // Shadow state
   // ------------------------
   logic [7:0] dbr_r, dbf_r, blkr_r, blkf_r;
   logic [3:0] frac_r, acc_r, mode_r;
   logic [5:0] steer_r, steer_q;
   logic [8:0] hi_r, lo_r, blk_r;
   logic       carry;
   assign carry = ({1'b0, acc_r} + {1'b0, frac_r}) > 5'h0f;
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         {dbr_r, dbf_r, blkr_r, blkf_r, frac_r} <= 36'h0;
         steer_r <= pet_pkg::STEER_RESET;
      end else if (reg_wr) begin
         case (reg_addr)
            pet_pkg::RISE_DEADBAND_OFF: dbr_r <= reg_wdata;
            pet_pkg::FALL_DEADBAND_OFF: dbf_r <= reg_wdata;
            pet_pkg::FRAC_ADJUST_OFF:   frac_r <= reg_wdata[3:0];
            pet_pkg::RISE_BLANKING_OFF: blkr_r <= reg_wdata;
            pet_pkg::FALL_BLANKING_OFF: blkf_r <= reg_wdata;
            pet_pkg::STEERING_OFF:      steer_r <= reg_wdata[5:0];
            default: ;
         endcase
      end
   end
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         {acc_r, mode_r, steer_q, hi_r, lo_r, blk_r} <= 41'h0;
      end else begin
         acc_r   <= period_event_in ? acc_r + frac_r : acc_r;
         mode_r  <= output_mode_select;
         steer_q <= steer_r;
         hi_r    <= pwm_raw ? hi_r + {8'h00, ~&hi_r} : 9'h000;
         lo_r    <= !pwm_raw ? lo_r + {8'h00, ~&lo_r} : 9'h000;
         blk_r   <= blanking_active ? blk_r + 9'h001 : 9'h000;
      end
   end
   sequence ev_now;
      !period_extend && period_event_out;
   endsequence
   sequence ev_late;
      period_extend && !period_event_out ##1 period_event_out;
   endsequence
   // ------------------------
   // Assertions
   // ------------------------
   rd_slot_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside its slot");
   unmapped_rd_a: assert property (reg_rd && reg_addr > 3'h5 |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   frac_upper_a: assert property (reg_rd && reg_addr == pet_pkg::FRAC_ADJUST_OFF |=> reg_rdata == {4'h0, frac_r})
      else $error("fractional read wrong");
   fb_blank_a: assert property (feedback_accepted |-> !$past(blanking_active))
      else $error("feedback taken while blanking");
   sd_blank_a: assert property (shutdown_accepted |-> !$past(blanking_active))
      else $error("shutdown taken while blanking");
   event_delay_a: assert property (period_event_in |=> ev_now or ev_late)
      else $error("period event not passed on");
   event_carry_a: assert property (period_event_in |=> period_extend == $past(carry))
      else $error("fractional carry wrong");
   rise_db_a: assert property ($rose(pwm_out[0]) && mode_r == 4'h0 && $past(mode_r) == 4'h0
      && steer_q[0] && $past(steer_q[0]) |-> hi_r == {1'b0, dbr_r} + 9'h002)
      else $error("rising dead band length wrong");
   fall_db_a: assert property ($rose(pwm_out[1]) && mode_r == 4'h1 && $past(mode_r) == 4'h1
      && steer_q[1] && $past(steer_q[1]) |-> lo_r == {1'b0, dbf_r} + 9'h002)
      else $error("falling dead band length wrong");
   blank_len_a: assert property ($fell(blanking_active) |-> blk_r == {1'b0, blkr_r} || blk_r == {1'b0, blkf_r})
      else $error("blanking length wrong");
   single_mask_a: assert property (mode_r == 4'h0 |-> (pwm_out & ~steer_q) == 6'h00)
      else $error("unsteered pin driven");
   three_phase_a: assert property (mode_r == 4'hc && steer_q == 6'h10 |-> pwm_out inside {6'h00, 6'h12})
      else $error("three phase pattern wrong");
endmodule

bind pet_edge_timing pet_edge_timing_sva i_pet_edge_timing_sva (.core_clk(core_clk), .reset_n(reset_n),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .pwm_raw(pwm_raw), .period_event_in(period_event_in), .output_mode_select(output_mode_select),
   .period_event_out(period_event_out), .period_extend(period_extend), .feedback_accepted(feedback_accepted),
   .shutdown_accepted(shutdown_accepted), .blanking_active(blanking_active), .pwm_out(pwm_out));

// ==== testbench/pet_stage_model.sv ====
// Power stage model: current sense follows the high-side switch
`timescale 1ns/1ps
module pet_stage_model (
   // Clock
   input wire logic       core_clk,
   // Switch drives and sense
   input wire logic [5:0] pwm_out,
   output logic           feedback_pin
);
   always @(posedge core_clk) feedback_pin <= pwm_out[0];
endmodule

// ==== testbench/tb_pet_edge_timing.sv ====
// Self-checking bench of the edge timing block
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin error_cnt++; $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb_pet_edge_timing;
   logic             core_clk, reset_n, reg_wr, reg_rd, pwm_raw, period_event_in, shutdown_pin, feedback_pin;
   logic             period_event_out, period_extend, feedback_accepted, shutdown_accepted, blanking_active;
   logic [2:0]       reg_addr;
   logic [7:0]       reg_wdata, reg_rdata, d;
   logic [3:0]       output_mode_select, m;
   logic [5:0]       pwm_out, s;
   logic [31:0]      seed = 32'hc39e8f34;
   int               error_cnt, compares, n, ev_cnt, ext_cnt, dr, df, ev0, ex0;
   int               regm [8];
   localparam int    RST [8] = '{0, 0, 0, 0, 0, 1, 0, 0};
   localparam int    MASK [8] = '{255, 255, 15, 255, 255, 63, 0, 0};
   localparam int    FR [4] = '{0, 1, 8, 255};
   localparam logic [3:0] MODES [4] = '{4'h0, 4'h1, 4'hc, 4'h7};
   localparam logic [5:0] PAT [6] = '{6'h09, 6'h21, 6'h11, 6'h06, 6'h12, 6'h18};

   pet_edge_timing i_pet_edge_timing (.core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pwm_raw(pwm_raw),
      .period_event_in(period_event_in), .output_mode_select(output_mode_select),
      .period_event_out(period_event_out), .period_extend(period_extend), .feedback_pin(feedback_pin),
      .shutdown_pin(shutdown_pin), .feedback_accepted(feedback_accepted), .shutdown_accepted(shutdown_accepted),
      .blanking_active(blanking_active), .pwm_out(pwm_out));
   pet_stage_model i_pet_stage_model (.core_clk(core_clk), .pwm_out(pwm_out), .feedback_pin(feedback_pin));

   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      ev_cnt  <= ev_cnt + int'(period_event_out);
      ext_cnt <= ext_cnt + int'(period_extend);
   end
   // ------------------------
   // Model and bus tasks
   // ------------------------
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [5:0] expo(logic [3:0] md, logic [5:0] st, logic p);
      logic [5:0] o;
      o = 6'h00;
      case (md)
         4'h0: o = p ? st : 6'h00;
         4'h1: o = p ? st & 6'h15 : st & 6'h2a;
         4'hc: for (int i = 0; i < 6; i++) if (st[i] && p) o |= PAT[i];
         default: o = 6'h00;
      endcase
      return o;
   endfunction
   task automatic tick(int c);
      repeat (c) @(posedge core_clk);
      #1;
   endtask
   task automatic close_out();
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic wr(logic [2:0] a, logic [7:0] v);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= v;
      regm[a] = v & MASK[a];
      tick(1);
      reg_wr <= 1'b0;
      tick(1);
   endtask
   task automatic rd_all();
      for (int a = 0; a < 8; a++) begin
         reg_rd   <= 1'b1;
         reg_addr <= a[2:0];
         tick(1);
         reg_rd <= 1'b0;
         `CHK(reg_rdata, regm[a][7:0])
         tick(1);
      end
   endtask
   task automatic meas(int idx, logic v, int e);
      n = 0;
      do begin
         tick(1);
         n++;
      end while (pwm_out[idx] !== v && n < 300);
      `CHK(n, e)
      if (n >= 300) close_out();
   endtask
   // ------------------------
   // Main sequence
   // ------------------------
   initial begin
      {reset_n, reg_wr, reg_rd, pwm_raw, period_event_in, shutdown_pin} = 6'h00;
      {reg_addr, reg_wdata, output_mode_select} = 15'h0;
      {error_cnt, compares} = '0;
      regm = RST;
      repeat (20) @(posedge core_clk);
      reset_n <= 1'b1;
      tick(1);
      rd_all();
      reg_wr <= 1'b1;
      for (int r = 0; r < 16; r++) begin
         d = 8'(rnd());
         reg_addr  <= r[2:0];
         reg_wdata <= d;
         regm[r % 8] = d & MASK[r % 8];
         tick(1);
      end
      reg_wr <= 1'b0;
      tick(1);
      rd_all();
      foreach (FR[i]) begin
         wr(3'h2, FR[i][7:0]);
         ev0 = ev_cnt;
         ex0 = ext_cnt;
         repeat (16) begin
            period_event_in <= 1'b1;
            tick(1);
            period_event_in <= 1'b0;
            tick(4);
         end
         `CHK(ev_cnt - ev0, 16)
         `CHK(ext_cnt - ex0, FR[i] & 15)
      end
      for (int r = 0; r < 4; r++) begin
         dr = r == 0 ? 0 : rnd() % 8;
         df = r == 0 ? 0 : rnd() % 8;
         wr(3'h0, dr[7:0]);
         wr(3'h1, df[7:0]);
         wr(3'h3, 8'(rnd() % 6));
         wr(3'h4, 8'(rnd() % 6));
         wr(3'h5, 8'h3f);
         output_mode_select <= 4'h0;
         tick(20);
         pwm_raw <= 1'b1;
         meas(0, 1'b1, dr + 2);
         tick(20);
         `CHK(feedback_accepted, 1'b1)
         pwm_raw <= 1'b0;
         output_mode_select <= 4'h1;
         tick(20);
         pwm_raw <= 1'b1;
         tick(20);
         pwm_raw <= 1'b0;
         meas(1, 1'b1, df + 2);
         tick(20);
      end
      for (int r = 0; r < 12; r++) begin
         m = MODES[r % 4];
         s = r < 4 ? 6'h10 : 6'(rnd());
         wr(3'h5, {2'b00, s});
         output_mode_select <= m;
         tick(20);
         `CHK(pwm_out, expo(m, s, 1'b0))
         pwm_raw <= 1'b1;
         tick(20);
         `CHK(pwm_out, expo(m, s, 1'b1))
         pwm_raw <= 1'b0;
         tick(1);
      end
      tick(20);
      shutdown_pin <= 1'b1;
      n = 0;
      while (shutdown_accepted !== 1'b1 && n < 20) begin
         tick(1);
         n++;
      end
      `CHK(n, 3)
      if (n >= 20) close_out();
      shutdown_pin <= 1'b0;
      reset_n <= 1'b0;
      tick(3);
      reset_n <= 1'b1;
      regm = RST;
      tick(1);
      rd_all();
      close_out();
   end
endmodule
